// File: can_interrupt_and_error_flags.sv
`timescale 1ns/1ps
`default_nettype none


module can_interrupt_and_error_flags (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic [7:0] regWrMask,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  input  wire logic [2:0] txEmptyEvt,
  input  wire logic [1:0] rxFullEvt,
  input  wire logic [1:0] rxOvfEvt,
  input  wire logic       msgErrEvt,
  input  wire logic       busActivity,
  input  wire logic       sleeping,
  input  wire logic [7:0] srcHold,
  input  wire logic [8:0] txErrCount,
  input  wire logic [7:0] rxErrCount,
  input  wire logic       recessive11,
  output logic            intN,
  output logic      [2:0] irqCode,
  output logic            wakeExit,
  output logic      [7:0] errorFlags
);

  logic [7:0] enableQ;
  logic [7:0] enableD;
  logic [7:0] flagQ;
  logic [7:0] flagD;
  logic [7:0] hwSet;
  logic [7:0] hold;
  logic [7:0] written;
  logic [7:0] pendD;
  logic       intNQ;
  logic       intND;
  logic [2:0] codeQ;
  logic [2:0] codeD;
  logic       wakeQ;
  logic       wakeD;
  logic [7:0] rdQ;
  logic [7:0] rdD;
  logic       wrEnable;
  logic       wrFlag;
  logic       wrError;
  logic [7:0] errFlags;
  logic       errEvt;

  assign wrEnable = regWrEn && (regAddr == can_irq_pkg::ADDR_IRQ_ENABLE);
  assign wrFlag   = regWrEn && (regAddr == can_irq_pkg::ADDR_IRQ_FLAG);
  assign wrError  = regWrEn && (regAddr == can_irq_pkg::ADDR_ERROR_FLAGS);

  error_flag_unit errorUnit (
    .clk         (clk),
    .reset       (reset),
    .txErrCount  (txErrCount),
    .rxErrCount  (rxErrCount),
    .recessive11 (recessive11),
    .rxOvfEvt    (rxOvfEvt),
    .wrEn        (wrError),
    .wrData      (regWrData),
    .wrMask      (regWrMask),
    .flags       (errFlags),
    .errEvt      (errEvt)
  );

  // Hardware set strobes, one per source
  always_comb begin
    hwSet = 8'h00;
    hwSet[can_irq_pkg::BIT_RX0]  = rxFullEvt[0];
    hwSet[can_irq_pkg::BIT_RX1]  = rxFullEvt[1];
    hwSet[can_irq_pkg::BIT_TX0]  = txEmptyEvt[0];
    hwSet[can_irq_pkg::BIT_TX1]  = txEmptyEvt[1];
    hwSet[can_irq_pkg::BIT_TX2]  = txEmptyEvt[2];
    hwSet[can_irq_pkg::BIT_ERR]  = errEvt;
    hwSet[can_irq_pkg::BIT_WAKE] = busActivity && sleeping &&
                                   enableQ[can_irq_pkg::BIT_WAKE];
    hwSet[can_irq_pkg::BIT_MERR] = msgErrEvt;
    hold = srcHold;
    // Error source stays asserted while an overflow is still flagged
    hold[can_irq_pkg::BIT_ERR] = srcHold[can_irq_pkg::BIT_ERR] |
      errFlags[can_irq_pkg::EF_RX0_OVF] | errFlags[can_irq_pkg::EF_RX1_OVF];
  end

  // Masked write merges only the selected bits, so a plain write is mask 8'hff
  assign written = (flagQ & ~regWrMask) | (regWrData & regWrMask);
  assign enableD = wrEnable ?
    ((enableQ & ~regWrMask) | (regWrData & regWrMask)) : enableQ;

  genvar i;
  generate
    for (i = 0; i < can_irq_pkg::NUM_SOURCES; i++) begin : g_flag
      // Host may set or clear; a held source only refuses the clear
      assign flagD[i] = hwSet[i] |
        (wrFlag ? (hold[i] ? (flagQ[i] | written[i]) : written[i]) : flagQ[i]);
    end
  endgenerate

  assign pendD = flagD & enableD;

  // Output and code follow the next state so they move with the flag edge
  always_comb begin
    intND = ~(|pendD);
    codeD = can_irq_pkg::CODE_NONE;
    for (int k = 0; k < can_irq_pkg::NUM_SOURCES; k++) begin
      if (pendD[k] && (can_irq_pkg::CODE_OF_BIT[k] != can_irq_pkg::CODE_NONE) &&
          ((codeD == can_irq_pkg::CODE_NONE) || (can_irq_pkg::CODE_OF_BIT[k] < codeD))) begin
        codeD = can_irq_pkg::CODE_OF_BIT[k];
      end
    end
    wakeD = hwSet[can_irq_pkg::BIT_WAKE];
  end

  // Read data is registered; unmapped addresses read zero
  always_comb begin
    rdD = rdQ;
    if (regRdEn) begin
      case (regAddr)
        can_irq_pkg::ADDR_IRQ_ENABLE:  rdD = enableQ;
        can_irq_pkg::ADDR_IRQ_FLAG:    rdD = flagQ;
        can_irq_pkg::ADDR_ERROR_FLAGS: rdD = errFlags;
        can_irq_pkg::ADDR_CTRL_STATUS: begin
          rdD = 8'h00;
          rdD[can_irq_pkg::CODE_LSB +: 3] = codeQ;
        end
        default:                       rdD = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      enableQ <= can_irq_pkg::IRQ_ENABLE_RESET;
      flagQ   <= can_irq_pkg::IRQ_FLAG_RESET;
      intNQ   <= 1'b1;
      codeQ   <= can_irq_pkg::CODE_NONE;
      wakeQ   <= 1'b0;
      rdQ     <= can_irq_pkg::READ_DATA_RESET;
    end else begin
      enableQ <= enableD;
      flagQ   <= flagD;
      intNQ   <= intND;
      codeQ   <= codeD;
      wakeQ   <= wakeD;
      rdQ     <= rdD;
    end
  end

  assign regRdData  = rdQ;
  assign intN       = intNQ;
  assign irqCode    = codeQ;
  assign wakeExit   = wakeQ;
  assign errorFlags = errFlags;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  intLevel_a: assert property ((|(flagQ & enableQ)) == !intN)
    else $error("intN disagrees with pending enabled flags");
  intHeld_a: assert property ((!intN && !wrEnable &&
    (|(flagQ & enableQ & ~(wrFlag ? (regWrMask & ~regWrData) : 8'h00)))) |=> !intN)
    else $error("intN released with other flags pending");
  rxSet_a: assert property (rxFullEvt[0] |=> flagQ[0])
    else $error("receive flag not set");
  txSet_a: assert property ((txEmptyEvt[2] && enableQ[4] && !wrEnable) |=> flagQ[4] && !intN)
    else $error("transmit flag or interrupt missing");
  setWins_a: assert property ((wrFlag && regWrMask[3] && !regWrData[3] && txEmptyEvt[1])
    |=> flagQ[3]) else $error("event lost to clear");
  holdClear_a: assert property ((wrFlag && srcHold[2] && flagQ[2]) |=> flagQ[2])
    else $error("held flag was cleared");
  clearWorks_a: assert property ((wrFlag && regWrMask[2] && !regWrData[2] && !srcHold[2]
    && !txEmptyEvt[0]) |=> !flagQ[2]) else $error("zero write did not clear");
  softSet_a: assert property ((wrFlag && regWrMask[1] && regWrData[1] && enableQ[1]
    && !wrEnable) |=> !intN && irqCode != 3'b000) else $error("host set gave no interrupt");
  errFirst_a: assert property ((flagQ[5] && enableQ[5]) |-> irqCode == 3'b001)
    else $error("error source not top priority");
  rx1Code_a: assert property (((flagQ & enableQ) == 8'h02) |-> irqCode == 3'b111)
    else $error("receive buffer 1 code wrong");
  nextCode_a: assert property (((flagQ & enableQ & 8'h7f) == 8'h00) |-> irqCode == 3'b000)
    else $error("code not none when idle");
  merrGate_a: assert property ((flagQ == 8'h80 && !enableQ[7]) |-> intN)
    else $error("disabled message error drove interrupt");
  wakeUp_a: assert property ((busActivity && sleeping && enableQ[6]) |=> wakeExit && flagQ[6])
    else $error("wakeup not taken");
  errEvtSet_a: assert property (errEvt |=> flagQ[5])
    else $error("error event did not set flag");

  twoPending_c: cover property ((flagQ[5] && flagQ[2] && (enableQ & 8'h24) == 8'h24)
    ##[1:20] irqCode == 3'b011);
  wake_c: cover property (wakeExit);
  allClear_c: cover property (!intN ##1 intN);

endmodule

`default_nettype wire

// File: can_irq_pkg.sv
package can_irq_pkg;

  // Register byte addresses on the register port
  localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'h2b;
  localparam logic [7:0] ADDR_IRQ_FLAG    = 8'h2c;
  localparam logic [7:0] ADDR_ERROR_FLAGS = 8'h2d;
  localparam logic [7:0] ADDR_CTRL_STATUS = 8'h0e;

  // Reset values
  localparam logic [7:0] IRQ_ENABLE_RESET  = 8'h00;
  localparam logic [7:0] IRQ_FLAG_RESET    = 8'h00;
  localparam logic [7:0] ERROR_FLAGS_RESET = 8'h00;
  localparam logic [7:0] READ_DATA_RESET   = 8'h00;

  // Bit positions shared by irq_enable_reg and irq_flag_reg
  localparam int BIT_RX0  = 0;
  localparam int BIT_RX1  = 1;
  localparam int BIT_TX0  = 2;
  localparam int BIT_TX1  = 3;
  localparam int BIT_TX2  = 4;
  localparam int BIT_ERR  = 5;
  localparam int BIT_WAKE = 6;
  localparam int BIT_MERR = 7;
  localparam int NUM_SOURCES = 8;

  // Bit positions of error_flags
  localparam int EF_SUMMARY_WARN = 0;
  localparam int EF_RX_WARN      = 1;
  localparam int EF_TX_WARN      = 2;
  localparam int EF_RX_PASSIVE   = 3;
  localparam int EF_TX_PASSIVE   = 4;
  localparam int EF_BUS_OFF      = 5;
  localparam int EF_RX0_OVF      = 6;
  localparam int EF_RX1_OVF      = 7;

  // Position of irq_priority_code inside controller_status_reg
  localparam int CODE_LSB = 1;

  // Error counter limits and bus-off recovery sequence count
  localparam logic [8:0] WARN_LIMIT    = 9'h060;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h080;
  localparam logic [8:0] BUS_OFF_LIMIT = 9'h100;
  localparam logic [7:0] RECOVERY_SEQS = 8'h80;

  typedef enum logic [2:0] {
    CODE_NONE = 3'b000,
    CODE_ERR  = 3'b001,
    CODE_WAKE = 3'b010,
    CODE_TX0  = 3'b011,
    CODE_TX1  = 3'b100,
    CODE_TX2  = 3'b101,
    CODE_RX0  = 3'b110,
    CODE_RX1  = 3'b111
  } irq_code_t;

  // Code of each flag bit; message error has no code of its own
  localparam irq_code_t CODE_OF_BIT [NUM_SOURCES] = '{
    CODE_RX0, CODE_RX1, CODE_TX0, CODE_TX1, CODE_TX2, CODE_ERR, CODE_WAKE, CODE_NONE
  };

endpackage

// File: error_flag_unit.sv
`timescale 1ns/1ps
`default_nettype none

module error_flag_unit (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [8:0] txErrCount,
  input  wire logic [7:0] rxErrCount,
  input  wire logic       recessive11,
  input  wire logic [1:0] rxOvfEvt,
  input  wire logic       wrEn,
  input  wire logic [7:0] wrData,
  input  wire logic [7:0] wrMask,
  output logic      [7:0] flags,
  output logic            errEvt
);

  logic [7:0] flagsQ;
  logic [7:0] flagsD;
  logic [7:0] recCntQ;
  logic [7:0] recCntD;
  logic       errEvtQ;
  logic       errEvtD;
  logic [8:0] rxWide;
  logic [7:0] written;

  assign rxWide  = {1'b0, rxErrCount};
  assign written = (flagsQ & ~wrMask) | (wrData & wrMask);

  always_comb begin
    flagsD = flagsQ;
    recCntD = recCntQ;
    flagsD[can_irq_pkg::EF_RX_WARN]    = rxWide >= can_irq_pkg::WARN_LIMIT;
    flagsD[can_irq_pkg::EF_TX_WARN]    = txErrCount >= can_irq_pkg::WARN_LIMIT;
    flagsD[can_irq_pkg::EF_SUMMARY_WARN] = flagsD[can_irq_pkg::EF_RX_WARN] |
                                           flagsD[can_irq_pkg::EF_TX_WARN];
    flagsD[can_irq_pkg::EF_RX_PASSIVE] = rxWide >= can_irq_pkg::PASSIVE_LIMIT;
    flagsD[can_irq_pkg::EF_TX_PASSIVE] = txErrCount >= can_irq_pkg::PASSIVE_LIMIT;
    // Bus-off is sticky until the full recovery sequence has been seen
    if (flagsQ[can_irq_pkg::EF_BUS_OFF]) begin
      if (recessive11) begin
        if (recCntQ == can_irq_pkg::RECOVERY_SEQS - 8'h01) begin
          flagsD[can_irq_pkg::EF_BUS_OFF] = 1'b0;
          recCntD = 8'h00;
        end else begin
          recCntD = recCntQ + 8'h01;
        end
      end
    end else begin
      recCntD = 8'h00;
      flagsD[can_irq_pkg::EF_BUS_OFF] = txErrCount >= can_irq_pkg::BUS_OFF_LIMIT;
    end
    // Overflow bits are host writable; a new overflow beats a clear
    flagsD[can_irq_pkg::EF_RX0_OVF] = rxOvfEvt[0] |
      (wrEn ? written[can_irq_pkg::EF_RX0_OVF] : flagsQ[can_irq_pkg::EF_RX0_OVF]);
    flagsD[can_irq_pkg::EF_RX1_OVF] = rxOvfEvt[1] |
      (wrEn ? written[can_irq_pkg::EF_RX1_OVF] : flagsQ[can_irq_pkg::EF_RX1_OVF]);
    errEvtD = (|rxOvfEvt) | (flagsD[5:1] != flagsQ[5:1]);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      flagsQ  <= can_irq_pkg::ERROR_FLAGS_RESET;
      recCntQ <= 8'h00;
      errEvtQ <= 1'b0;
    end else begin
      flagsQ  <= flagsD;
      recCntQ <= recCntD;
      errEvtQ <= errEvtD;
    end
  end

  assign flags  = flagsQ;
  assign errEvt = errEvtQ;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  warnFollows_a: assert property ((txErrCount >= 9'h060 || rxErrCount >= 8'h60)
    |=> flagsQ[0]) else $error("summary warning not set");
  warnClears_a: assert property ((txErrCount < 9'h060 && rxErrCount < 8'h60)
    |=> !flagsQ[0]) else $error("summary warning not cleared");
  passiveTx_a: assert property ((txErrCount >= 9'h080) |=> flagsQ[4] && flagsQ[2])
    else $error("tx passive flag wrong");
  passiveRx_a: assert property ((rxErrCount < 8'h80) |=> !flagsQ[3])
    else $error("rx passive flag not cleared");
  busOffSet_a: assert property ((!flagsQ[5] && txErrCount[8]) |=> flagsQ[5])
    else $error("bus-off not entered");
  busOffHold_a: assert property ((flagsQ[5] && !recessive11) |=> flagsQ[5])
    else $error("bus-off left without recovery");

  recovery_c: cover property (flagsQ[5] ##1 !flagsQ[5]);

endmodule

`default_nettype wire

// File: host_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_model (
  input  wire logic       clk,
  input  wire logic [7:0] regRdData,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData,
  output logic      [7:0] regWrMask,
  output logic            regWrEn,
  output logic            regRdEn
);
  initial begin
    {regAddr, regWrData, regWrMask, regWrEn, regRdEn} = '0;
  end

  // Idle lines invert so a stale address or datum is never taken as valid
  task automatic release_bus();
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
    regAddr   = ~regAddr;
    regWrData = ~regWrData;
  endtask

  // Flags are cleared by a write of zero under a set mask bit, a plain write included
  task automatic wr(input logic [7:0] addr, input logic [7:0] data, input logic [7:0] mask);
    @(posedge clk);
    #2;
    regAddr   = addr;
    regWrData = data; // zero clears a flag
    regWrMask = mask; // only chosen bits touched
    regWrEn   = 1'b1;
    @(posedge clk);
    #2;
    release_bus();
  endtask

  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk);
    #2;
    regAddr = addr;
    regRdEn = 1'b1;
    @(posedge clk);
    #2;
    data = regRdData;
    release_bus();
  endtask
endmodule

`default_nettype wire

// File: tb_can_interrupt_and_error_flags.sv
`timescale 1ns/1ps
`default_nettype none

module tb_can_interrupt_and_error_flags;
  localparam int LIMIT = 4000;
  localparam logic [2:0] EXP [7] = '{3'h6, 3'h7, 3'h3, 3'h4, 3'h5, 3'h1, 3'h2};
  logic            clk;
  logic            reset;
  wire logic [7:0] regAddr;
  wire logic [7:0] regWrData;
  wire logic [7:0] regWrMask;
  wire logic       regWrEn;
  wire logic       regRdEn;
  logic      [7:0] regRdData;
  logic      [2:0] txEmptyEvt;
  logic      [1:0] rxFullEvt;
  logic      [1:0] rxOvfEvt;
  logic            msgErrEvt;
  logic            busActivity;
  logic            sleeping;
  logic      [7:0] srcHold;
  logic      [8:0] txErrCount;
  logic      [7:0] rxErrCount;
  logic            recessive11;
  logic            intN;
  logic      [2:0] irqCode;
  logic            wakeExit;
  logic      [7:0] errorFlags;
  logic      [7:0] rdv;
  int              nMismatch = 0;
  int              compares = 0;
  int              cycles = 0;

  host_model host (.clk(clk), .regRdData(regRdData), .regAddr(regAddr),
    .regWrData(regWrData), .regWrMask(regWrMask), .regWrEn(regWrEn), .regRdEn(regRdEn));

  can_interrupt_and_error_flags DUT (.clk(clk), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrMask(regWrMask), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .txEmptyEvt(txEmptyEvt), .rxFullEvt(rxFullEvt),
    .rxOvfEvt(rxOvfEvt), .msgErrEvt(msgErrEvt), .busActivity(busActivity),
    .sleeping(sleeping), .srcHold(srcHold), .txErrCount(txErrCount),
    .rxErrCount(rxErrCount), .recessive11(recessive11), .intN(intN), .irqCode(irqCode),
    .wakeExit(wakeExit), .errorFlags(errorFlags));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      nMismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n = 1);
    repeat (n) begin
      @(posedge clk);
      #2;
    end
  endtask

  task automatic st(input logic expIntN, input logic [2:0] code);
    check({7'h00, intN}, {7'h00, expIntN});
    check({5'h00, irqCode}, {5'h00, code});
  endtask

  task automatic rdc(input logic [7:0] addr, input logic [7:0] exp);
    host.rd(addr, rdv);
    check(rdv, exp);
  endtask

  task automatic summarize();
    $display("Counts: mismatches=%0d compares=%0d", nMismatch, compares);
    if (nMismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      nMismatch++;
      summarize();
    end
  end

  initial begin
    reset = 1'b1;
    {txEmptyEvt, rxFullEvt, rxOvfEvt, msgErrEvt, busActivity, sleeping} = '0;
    {srcHold, txErrCount, rxErrCount, recessive11} = '0;
    tick(2);
    reset = 1'b0;
    st(1'b1, can_irq_pkg::CODE_NONE); // idle after reset
    rdc(can_irq_pkg::ADDR_IRQ_ENABLE, 8'h00); // enables clear
    rdc(can_irq_pkg::ADDR_IRQ_FLAG, 8'h00); // flags clear
    rdc(can_irq_pkg::ADDR_ERROR_FLAGS, 8'h00); // error flags clear
    rdc(8'h55, 8'h00); // unmapped read
    host.wr(can_irq_pkg::ADDR_IRQ_ENABLE, 8'hff, 8'hff);
    for (int i = 0; i < 7; i++) begin
      host.wr(can_irq_pkg::ADDR_IRQ_FLAG, 8'hff, 8'h01 << i);
      st(1'b0, EXP[i]); // host set raises code
      rdc(can_irq_pkg::ADDR_CTRL_STATUS, {4'h0, EXP[i], 1'b0}); // status code
      host.wr(can_irq_pkg::ADDR_IRQ_FLAG, 8'h00, 8'h01 << i);
      st(1'b1, 3'h0); // cleared
    end
    {txEmptyEvt, rxFullEvt} = 5'h1f;
    tick();
    {txEmptyEvt, rxFullEvt} = 5'h00;
    st(1'b0, 3'h3); // events at once
    rdc(can_irq_pkg::ADDR_IRQ_FLAG, 8'h1f); // event flags
    host.wr(can_irq_pkg::ADDR_IRQ_FLAG, 8'h00, 8'h04);
    st(1'b0, 3'h4); // next source
    host.wr(can_irq_pkg::ADDR_IRQ_FLAG, 8'h00, 8'h18);
    st(1'b0, 3'h6); // next source
    host.wr(can_irq_pkg::ADDR_IRQ_FLAG, 8'h00, 8'h01);
    st(1'b0, 3'h7); // still pending
    host.wr(can_irq_pkg::ADDR_IRQ_FLAG, 8'h00, 8'h02);
    st(1'b1, 3'h0); // all cleared
    host.wr(can_irq_pkg::ADDR_IRQ_ENABLE, 8'h00, 8'h04);
    txEmptyEvt = 3'h1;
    srcHold = 8'h04;
    tick();
    txEmptyEvt = 3'h0;
    st(1'b1, 3'h0); // disabled source hidden
    host.wr(can_irq_pkg::ADDR_IRQ_FLAG, 8'h00, 8'h04);
    rdc(can_irq_pkg::ADDR_IRQ_FLAG, 8'h04); // clear refused
    srcHold = 8'h00;
    host.wr(can_irq_pkg::ADDR_IRQ_FLAG, 8'h00, 8'h04);
    rdc(can_irq_pkg::ADDR_IRQ_FLAG, 8'h00); // clear accepted
    fork
      host.wr(can_irq_pkg::ADDR_IRQ_FLAG, 8'h00, 8'h08);
      begin
        tick();
        txEmptyEvt = 3'h2;
        tick();
        txEmptyEvt = 3'h0;
      end
    join
    st(1'b0, 3'h4); // event beats clear
    host.wr(can_irq_pkg::ADDR_IRQ_FLAG, 8'h00, 8'hff);
    host.wr(can_irq_pkg::ADDR_IRQ_ENABLE, 8'h00, 8'h80);
    msgErrEvt = 1'b1;
    tick();
    msgErrEvt = 1'b0;
    st(1'b1, 3'h0); // gated by enable
    rdc(can_irq_pkg::ADDR_IRQ_FLAG, 8'h80); // flag set anyway
    host.wr(can_irq_pkg::ADDR_IRQ_ENABLE, 8'hff, 8'hff);
    st(1'b0, 3'h0); // interrupt without code
    host.wr(can_irq_pkg::ADDR_IRQ_FLAG, 8'h00, 8'h80);
    busActivity = 1'b1;
    rdc(can_irq_pkg::ADDR_IRQ_FLAG, 8'h00); // awake, no flag
    sleeping = 1'b1;
    tick();
    {busActivity, sleeping} = 2'b00;
    check({7'h00, wakeExit}, 8'h01); // leave sleep
    st(1'b0, 3'h2); // wake source
    tick();
    check({7'h00, wakeExit}, 8'h00); // one pulse
    host.wr(can_irq_pkg::ADDR_IRQ_FLAG, 8'h00, 8'h40);
    txErrCount = 9'h05f;
    tick(3);
    check(errorFlags, 8'h00); // below limit
    txErrCount = 9'h060;
    tick(3);
    rdc(can_irq_pkg::ADDR_ERROR_FLAGS, 8'h05); // warning
    st(1'b0, 3'h1); // state change
    host.wr(can_irq_pkg::ADDR_IRQ_FLAG, 8'h00, 8'h20);
    txErrCount = 9'h080;
    rxErrCount = 8'h80;
    tick(3);
    check(errorFlags, 8'h1f); // both passive
    rxErrCount = 8'h7f;
    tick(3);
    check(errorFlags, 8'h17); // receive passive drops
    txErrCount = 9'h100;
    tick(3);
    check(errorFlags, 8'h37); // bus off
    host.wr(can_irq_pkg::ADDR_ERROR_FLAGS, 8'h00, 8'h3f);
    check(errorFlags, 8'h37); // status bits read only
    txErrCount = 9'h000;
    rxErrCount = 8'h00;
    for (int i = 0; i < 128; i++) begin
      if (i == 127) begin
        check(errorFlags, 8'h20); // held until last sequence
      end
      recessive11 = 1'b1;
      tick();
      recessive11 = 1'b0;
      tick();
    end
    tick(2);
    check(errorFlags, 8'h00); // recovered
    rxOvfEvt = 2'h3;
    tick();
    rxOvfEvt = 2'h0;
    tick(3);
    check(errorFlags, 8'hc0); // overflow
    st(1'b0, 3'h1); // overflow interrupt
    host.wr(can_irq_pkg::ADDR_IRQ_FLAG, 8'h00, 8'h20);
    rdc(can_irq_pkg::ADDR_IRQ_FLAG, 8'h20); // error clear refused
    host.wr(can_irq_pkg::ADDR_ERROR_FLAGS, 8'h00, 8'hc0);
    check(errorFlags, 8'h00); // overflow bits cleared
    host.wr(can_irq_pkg::ADDR_IRQ_FLAG, 8'h00, 8'hff);
    st(1'b1, 3'h0); // all serviced
    summarize();
  end
endmodule

`default_nettype wire
